// file: ick_key_builder.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "ick_map.svh"
module ick_key_builder #(
    parameter int NUM_RNG = 8
) (
    input logic clk,
    input logic nrst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic frm_valid,
    input ick_pkg::ick_frame_t frm_type,
    input logic ip_mf,
    input logic [12:0] ip_frag_ofs,
    input logic [3:0] ip_ihl,
    input logic [5:0] dscp_xlat,
    input logic [127:0] ip_dst,
    input logic [127:0] ip_src,
    input logic [7:0] l4_proto,
    input logic [31:0] l4_word,
    input logic [127:0] payload,
    input logic [7:0] llc_ctrl,
    input logic [39:0] snap_pid,
    input logic vlan_tagged,
    input logic [11:0] vlan_tag_vid,
    output logic key_valid,
    output logic [`ICK_K7_W-1:0] seven_tuple_key,
    output logic [`ICK_K5_W-1:0] ipv6_five_tuple_key
);
    import ick_pkg::*;

    // All flip-flops of the block in one record.
    typedef struct packed {
        logic [NUM_RNG-1:0][15:0] lo;
        logic [NUM_RNG-1:0][15:0] hi;
        logic [NUM_RNG-1:0][2:0] rtyp;
        logic [11:0] pvid;
        logic kvalid;
        logic [7:0] kcount;
        logic [7:0] lastrng;
        logic [31:0] prdata;
        logic [`ICK_K7_W-1:0] key7;
        logic [`ICK_K5_W-1:0] key5;
    } ick_state_t;

    ick_state_t st_q;
    ick_state_t st_d;
    logic [NUM_RNG-1:0] rng_hit;
    logic [`ICK_K7_W-1:0] k7_c;
    logic [`ICK_K5_W-1:0] k5_c;
    logic is4;
    logic is6;
    logic tu;
    logic tcp;
    logic [63:0] dlo;
    logic [63:0] slo;
    logic [11:0] rng_vid;
    logic acc;

    // Aligned address inside the map; shared by read, write, error.
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) &&
            (a < `ICK_REG_TYPES || a == `ICK_REG_TYPES ||
             a == `ICK_REG_PVID || a == `ICK_REG_STAT);
    endfunction

    // Eight consecutive payload bytes; byte 0 sits in the top lane.
    function automatic logic [63:0] pbytes(input logic [127:0] p,
                                           input int first);
        return p[127 - 8 * first -: 64];
    endfunction

    // Read value of one register, zero where nothing is mapped.
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input ick_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (!mapped(a)) begin
            w = 32'h0000_0000;
        end else if (a < `ICK_REG_TYPES) begin
            w = {s.hi[a[4:2]], s.lo[a[4:2]]};
        end else if (a == `ICK_REG_TYPES) begin
            w = {8'h00, s.rtyp};
        end else if (a == `ICK_REG_PVID) begin
            w = {20'h00000, s.pvid};
        end else begin
            w = {16'h0000, s.kcount, s.lastrng};
        end
        return w;
    endfunction

    // Untagged frames are checked against the port default VLAN.
    assign rng_vid = vlan_tagged ? vlan_tag_vid : st_q.pvid;

    // One checker per mask bit, each with its own bounds and type.
    for (genvar i = 0; i < NUM_RNG; i++) begin : g_rng
        ick_range_chk u_chk (
            .rtype(st_q.rtyp[i]),
            .lo(st_q.lo[i]),
            .hi(st_q.hi[i]),
            .port_ok(tu),
            .sport(l4_word[31:16]),
            .dport(l4_word[15:0]),
            .vid(rng_vid),
            .dscp(dscp_xlat),
            .hit(rng_hit[i])
        );
    end

    // Frame class decode.
    assign is4 = frm_type == ICK_FT_IPV4;
    assign is6 = frm_type == ICK_FT_IPV6;
    assign tu = (is4 || is6) &&
        (l4_proto == `ICK_PROTO_TCP || l4_proto == `ICK_PROTO_UDP);
    assign tcp = (is4 || is6) && l4_proto == `ICK_PROTO_TCP;

    // Overloaded address fields. Options are never skipped, so for
    // optioned IPv4 the layer-4 word is whatever follows 20 bytes.
    always_comb begin
        case (frm_type)
            ICK_FT_LLC: begin
                dlo = pbytes(payload, 7);
                slo = {llc_ctrl, payload[127:72]};
            end
            ICK_FT_SNAP: begin
                dlo = pbytes(payload, 5);
                slo = {snap_pid[23:0], payload[127:88]};
            end
            ICK_FT_IPV4: begin
                dlo = {32'h0000_0000, ip_dst[31:0]};
                slo = {32'h0000_0000, ip_src[31:0]};
            end
            ICK_FT_IPV6: begin
                dlo = ip_dst[63:0];
                slo = ip_src[63:0];
            end
            ICK_FT_OAM, ICK_FT_ARP, ICK_FT_ETYPE: begin
                dlo = pbytes(payload, 8);
                slo = pbytes(payload, 0);
            end
            default: begin
                dlo = 64'h0;
                slo = 64'h0;
            end
        endcase
    end

    // Both key formats come from the same parse in the same cycle.
    // Bits below 180 of the seven-tuple key belong elsewhere.
    always_comb begin
        k7_c = '0;
        k5_c = '0;
        k7_c[`ICK_K7_FRAG] = is4 && (ip_mf || ip_frag_ofs != 13'h0);
        k7_c[`ICK_K7_NFF] = is4 && ip_frag_ofs != 13'h0;
        k7_c[`ICK_K7_OPT] = is4 && ip_ihl > `ICK_IHL_BASE;
        k7_c[`ICK_K7_DSCP +: 6] = dscp_xlat;
        k7_c[`ICK_K7_DLO +: 64] = dlo;
        k7_c[`ICK_K7_SLO +: 64] = slo;
        k7_c[`ICK_K7_TU] = tu;
        k7_c[`ICK_K7_TCP] = tcp;
        k7_c[`ICK_K7_SPORT +: 16] = tu ? l4_word[31:16] : 16'h0000;
        k7_c[`ICK_K7_RNG +: 8] = rng_hit;
        k5_c[`ICK_K5_DSCP +: 6] = dscp_xlat;
        k5_c[`ICK_K5_RNG +: 8] = rng_hit;
        if (is6) begin
            k7_c[`ICK_K7_DHI +: 16] = ip_dst[127:112];
            k7_c[`ICK_K7_SHI +: 16] = ip_src[127:112];
            k5_c[`ICK_K5_DIP +: 128] = ip_dst;
            k5_c[`ICK_K5_SIP +: 128] = ip_src;
            k5_c[`ICK_K5_PROTO +: 8] = l4_proto;
            k5_c[`ICK_K5_TU] = tu;
            k5_c[`ICK_K5_TCP] = tcp;
            k5_c[`ICK_K5_PAY +: 32] = l4_word;
        end
    end

    // APB access phase; the slave never inserts wait states.
    assign acc = psel && penable;

    // Next state: register writes, read capture and key capture.
    // Read data is captured in the setup cycle so prdata is a flop.
    always_comb begin
        st_d = st_q;
        if (psel && !penable) begin
            st_d.prdata = rd_word(paddr, st_q);
        end
        if (acc && pwrite && mapped(paddr)) begin
            if (paddr < `ICK_REG_TYPES) begin
                st_d.lo[paddr[4:2]] = pwdata[15:0];
                st_d.hi[paddr[4:2]] = pwdata[31:16];
            end else if (paddr == `ICK_REG_TYPES) begin
                st_d.rtyp = pwdata[23:0];
            end else if (paddr == `ICK_REG_PVID) begin
                st_d.pvid = pwdata[11:0];
            end
        end
        st_d.kvalid = frm_valid;
        if (frm_valid) begin
            st_d.key7 = k7_c;
            st_d.key5 = k5_c;
            st_d.lastrng = rng_hit;
            st_d.kcount = st_q.kcount + 8'h01;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.lo <= {NUM_RNG{`ICK_RST_LO}};
            st_q.hi <= {NUM_RNG{`ICK_RST_HI}};
            st_q.rtyp <= {NUM_RNG{`ICK_RST_TYPE}};
            st_q.pvid <= `ICK_RST_PVID;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs.
    assign prdata = st_q.prdata;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped(paddr);
    assign key_valid = st_q.kvalid;
    assign seven_tuple_key = st_q.key7;
    assign ipv6_five_tuple_key = st_q.key5;

    // Checks on the registered keys.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_v4;
        frm_valid && frm_type == ICK_FT_IPV4;
    endsequence

    sequence s_v6;
        frm_valid && frm_type == ICK_FT_IPV6;
    endsequence

    sequence s_v4_dst;
        s_v4 ##1
            seven_tuple_key[`ICK_K7_DLO +: 64] ==
            {32'h0, $past(ip_dst[31:0])};
    endsequence

    // Port fields are only meaningful for TCP or UDP over IP.
    sequence s_l4;
        frm_valid && (frm_type == ICK_FT_IPV4 || frm_type == ICK_FT_IPV6)
            && (l4_proto == `ICK_PROTO_TCP || l4_proto == `ICK_PROTO_UDP);
    endsequence

    frag_flag_a: assert property (
        s_v4 ##0 (ip_mf || ip_frag_ofs != 13'h0) |=>
            seven_tuple_key[`ICK_K7_FRAG])
        else $error("fragment flag missing for IPv4 frame");

    nonfirst_frag_a: assert property (
        frm_valid |=> seven_tuple_key[`ICK_K7_NFF] ==
            ($past(frm_type) == ICK_FT_IPV4 && $past(ip_frag_ofs) != 0))
        else $error("non-first fragment flag wrong");

    opt_flag_a: assert property (
        frm_valid |=> seven_tuple_key[`ICK_K7_OPT] ==
            ($past(frm_type) == ICK_FT_IPV4 &&
             $past(ip_ihl) > `ICK_IHL_BASE))
        else $error("options flag wrong");

    dscp_keys_a: assert property (
        frm_valid |=> seven_tuple_key[`ICK_K7_DSCP +: 6] ==
            $past(dscp_xlat) && ipv6_five_tuple_key[`ICK_K5_DSCP +: 6]
            == seven_tuple_key[`ICK_K7_DSCP +: 6])
        else $error("DSCP field differs from translated value");

    dst_high_a: assert property (
        s_v6 |=> ipv6_five_tuple_key[`ICK_K5_DIP +: 128] == $past(ip_dst)
            && seven_tuple_key[`ICK_K7_DHI +: 16] ==
            ipv6_five_tuple_key[`ICK_K5_DIP + 112 +: 16])
        else $error("IPv6 destination fields wrong");

    src_high_a: assert property (
        s_v6 |=> ipv6_five_tuple_key[`ICK_K5_SIP +: 128] == $past(ip_src)
            && seven_tuple_key[`ICK_K7_SHI +: 16] ==
            ipv6_five_tuple_key[`ICK_K5_SIP + 112 +: 16])
        else $error("IPv6 source fields wrong");

    dst_low_v4_a: assert property (
        s_v4 |-> s_v4_dst)
        else $error("IPv4 destination not in low field");

    l4_flags_a: assert property (
        key_valid && seven_tuple_key[`ICK_K7_TCP] |->
            seven_tuple_key[`ICK_K7_TU])
        else $error("TCP flag without TCP_OR_UDP_FLAG flag");

    rng_copy_a: assert property (
        key_valid |-> seven_tuple_key[`ICK_K7_RNG +: 8] ==
            ipv6_five_tuple_key[`ICK_K5_RNG +: 8])
        else $error("range masks of the two keys differ");

    pay_v6_a: assert property (
        s_v6 |=> ipv6_five_tuple_key[`ICK_K5_PAY +: 32] == $past(l4_word)
            && ipv6_five_tuple_key[`ICK_K5_TU] ==
            seven_tuple_key[`ICK_K7_TU])
        else $error("IPv6 post-header word or flag wrong");

    key_on_a: assert property (
        frm_valid |=> key_valid ##1 (key_valid == $past(frm_valid)))
        else $error("key not presented one cycle after parse");

    key_off_a: assert property (
        !frm_valid |=> !key_valid)
        else $error("key valid without a parse");

    // Further field checks; the count check guards the status word.
    src_low_v4_a: assert property (
        s_v4 |=> seven_tuple_key[`ICK_K7_SLO +: 64] ==
            {32'h0, $past(ip_src[31:0])})
        else $error("IPv4 source not in low field");

    proto_five_a: assert property (
        s_v6 |=> ipv6_five_tuple_key[`ICK_K5_PROTO +: 8] ==
            $past(l4_proto))
        else $error("next header field wrong");

    sport_field_a: assert property (
        s_l4 |=> seven_tuple_key[`ICK_K7_TU] &&
            seven_tuple_key[`ICK_K7_SPORT +: 16] == $past(l4_word[31:16]))
        else $error("source port or TCP_OR_UDP_FLAG flag wrong");

    five_l4_flag_a: assert property (
        s_l4 ##0 frm_type == ICK_FT_IPV6 |=>
            ipv6_five_tuple_key[`ICK_K5_TU])
        else $error("five-tuple TCP_OR_UDP_FLAG flag missing");

    v6_only_a: assert property (
        frm_valid && frm_type != ICK_FT_IPV6 |=>
            ipv6_five_tuple_key[`ICK_K5_DIP +: 256] == '0 &&
            seven_tuple_key[`ICK_K7_DHI +: 16] == 16'h0000)
        else $error("IPv6-only fields set for another frame type");

    count_step_a: assert property (
        frm_valid |=> st_q.kcount == $past(st_q.kcount) + 8'h01)
        else $error("frame count did not advance");

endmodule // ick_key_builder

// file: ick_map.svh
`ifndef ICK_MAP_SVH
`define ICK_MAP_SVH


// Key widths, covering the highest field of each format.
`define ICK_K7_W 375
`define ICK_K5_W 377

// Seven-tuple key field positions.
`define ICK_K7_FRAG 180
`define ICK_K7_NFF 181
`define ICK_K7_OPT 182
`define ICK_K7_DSCP 183
`define ICK_K7_DHI 189
`define ICK_K7_DLO 205
`define ICK_K7_SHI 269
`define ICK_K7_SLO 285
`define ICK_K7_TU 349
`define ICK_K7_TCP 350
`define ICK_K7_SPORT 351
`define ICK_K7_RNG 367

// IPv6 five-tuple key field positions.
`define ICK_K5_DSCP 65
`define ICK_K5_DIP 71
`define ICK_K5_SIP 199
`define ICK_K5_PROTO 327
`define ICK_K5_TU 335
`define ICK_K5_TCP 336
`define ICK_K5_RNG 337
`define ICK_K5_PAY 345

// Header constants.
`define ICK_IHL_BASE 4'h5
`define ICK_PROTO_TCP 8'h06
`define ICK_PROTO_UDP 8'h11

// Register byte offsets and reset values.
`define ICK_REG_BOUNDS 8'h00
`define ICK_REG_TYPES 8'h20
`define ICK_REG_PVID 8'h24
`define ICK_REG_STAT 8'h28
`define ICK_RST_LO 16'h0000
`define ICK_RST_HI 16'hffff
`define ICK_RST_TYPE 3'h0
`define ICK_RST_PVID 12'h001

`endif

// file: ick_pkg.sv
package ick_pkg;

    // Frame classes reported by the parser.
    typedef enum logic [2:0] {
        ICK_FT_LLC = 3'h0,
        ICK_FT_SNAP = 3'h1,
        ICK_FT_IPV4 = 3'h2,
        ICK_FT_IPV6 = 3'h3,
        ICK_FT_OAM = 3'h4,
        ICK_FT_ARP = 3'h5,
        ICK_FT_ETYPE = 3'h6
    } ick_frame_t;

    // Quantity a range checker tests.
    typedef enum logic [2:0] {
        ICK_RT_OFF = 3'h0,
        ICK_RT_SPORT = 3'h1,
        ICK_RT_DPORT = 3'h2,
        ICK_RT_EITHER = 3'h3,
        ICK_RT_VID = 3'h4,
        ICK_RT_DSCP = 3'h5
    } ick_rng_t;

endpackage

// file: ick_range_chk.sv
`timescale 1ns/10ps
module ick_range_chk (
    input logic [2:0] rtype,
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic port_ok,
    input logic [15:0] sport,
    input logic [15:0] dport,
    input logic [11:0] vid,
    input logic [5:0] dscp,
    output logic hit
);
    import ick_pkg::*;

    // Inclusive bound test shared by every range type except ICK_RT_OFF.
    function automatic logic in_rng(input logic [15:0] v,
                                    input logic [15:0] l,
                                    input logic [15:0] h);
        return (v >= l) && (v <= h);
    endfunction

    // Port ranges only count for frames that really carry ports.
    always_comb begin
        case (ick_rng_t'(rtype))
            ICK_RT_SPORT: hit = port_ok && in_rng(sport, lo, hi);
            ICK_RT_DPORT: hit = port_ok && in_rng(dport, lo, hi);
            ICK_RT_EITHER: hit = port_ok &&
                (in_rng(sport, lo, hi) || in_rng(dport, lo, hi));
            ICK_RT_VID: hit = in_rng({4'h0, vid}, lo, hi);
            ICK_RT_DSCP: hit = in_rng({10'h000, dscp}, lo, hi);
            default: hit = 1'b0;
        endcase
    end
endmodule // ick_range_chk

// file: ick_parser_model.sv
`timescale 1ns/10ps
module ick_parser_model #(
    parameter logic [127:0] DST = '0,
    parameter logic [127:0] SRC = '0,
    parameter logic [127:0] PAY = '0,
    parameter logic [31:0] L4 = '0
) (
    input logic clk,
    output logic frm_valid,
    output ick_pkg::ick_frame_t frm_type,
    output logic ip_mf,
    output logic [12:0] ip_frag_ofs,
    output logic [3:0] ip_ihl,
    output logic [5:0] dscp_xlat,
    output logic [127:0] ip_dst,
    output logic [127:0] ip_src,
    output logic [7:0] l4_proto,
    output logic [31:0] l4_word,
    output logic [127:0] payload,
    output logic [7:0] llc_ctrl,
    output logic [39:0] snap_pid,
    output logic vlan_tagged,
    output logic [11:0] vlan_tag_vid
);
    import ick_pkg::*;

    // Outside a frame the data lines carry inverted values, so a key
    // that samples them at the wrong cycle comes out wrong.
    task automatic idle();
        frm_valid <= 1'b0;
        ip_dst <= ~DST;
        ip_src <= ~SRC;
        payload <= ~PAY;
        l4_word <= ~L4;
        llc_ctrl <= 8'ha5;
        snap_pid <= 40'hf5f4f3f2f1;
    endtask

    // One parse result, valid for exactly one cycle.
    task automatic send(input ick_frame_t t, input logic [7:0] pr,
                        input logic mf, input logic [12:0] ofs,
                        input logic [3:0] ihl, input logic [5:0] ds,
                        input logic tag);
        @(posedge clk);
        frm_valid <= 1'b1;
        frm_type <= t;
        ip_mf <= mf;
        ip_frag_ofs <= ofs;
        ip_ihl <= ihl;
        dscp_xlat <= ds;
        l4_proto <= pr;
        vlan_tagged <= tag;
        ip_dst <= DST;
        ip_src <= SRC;
        payload <= PAY;
        l4_word <= L4;
        llc_ctrl <= 8'h5a;
        snap_pid <= 40'h0a0b0c0d0e;
        @(posedge clk);
        idle();
    endtask

    // Time-zero values for every line.
    initial begin
        idle();
        frm_type <= ICK_FT_LLC;
        ip_mf <= 1'b0;
        ip_frag_ofs <= 13'h0;
        ip_ihl <= 4'h5;
        dscp_xlat <= 6'h0;
        l4_proto <= 8'h0;
        vlan_tagged <= 1'b0;
        vlan_tag_vid <= 12'h123;
    end
endmodule // ick_parser_model

// file: ick_key_builder_tb.sv
`timescale 1ns/10ps
module ick_key_builder_tb;
    import ick_pkg::*;
    localparam logic [127:0] DST = 128'h0123456789abcdeffedcba9876543210;
    localparam logic [127:0] SRC = 128'h2468ace013579bdf0f1e2d3c4b5a6978;
    localparam logic [127:0] PAY = 128'h00112233445566778899aabbccddeeff;
    localparam logic [31:0] L4 = 32'h00961388;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, fv, mf, tg, kv;
    ick_frame_t ft;
    logic [12:0] ofs;
    logic [3:0] ihl;
    logic [5:0] ds;
    logic [127:0] dst, src, pay;
    logic [7:0] pr, ctl;
    logic [31:0] l4w;
    logic [39:0] pid;
    logic [11:0] vid;
    logic [374:0] k7;
    logic [376:0] k5;
    logic [63:0] ed, es;
    int err_count = 0;
    int checks_done = 0;
    int nfr = 0;
    int wt = 0;

    always #25 clk = ~clk;

    ick_parser_model #(.DST(DST), .SRC(SRC), .PAY(PAY), .L4(L4)) parser_i (
        .clk(clk), .frm_valid(fv), .frm_type(ft), .ip_mf(mf),
        .ip_frag_ofs(ofs), .ip_ihl(ihl), .dscp_xlat(ds), .ip_dst(dst),
        .ip_src(src), .l4_proto(pr), .l4_word(l4w), .payload(pay),
        .llc_ctrl(ctl), .snap_pid(pid), .vlan_tagged(tg),
        .vlan_tag_vid(vid));

    ick_key_builder ick_key_builder_i (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frm_valid(fv), .frm_type(ft),
        .ip_mf(mf), .ip_frag_ofs(ofs), .ip_ihl(ihl), .dscp_xlat(ds),
        .ip_dst(dst), .ip_src(src), .l4_proto(pr), .l4_word(l4w),
        .payload(pay), .llc_ctrl(ctl), .snap_pid(pid), .vlan_tagged(tg),
        .vlan_tag_vid(vid), .key_valid(kv), .seven_tuple_key(k7),
        .ipv6_five_tuple_key(k5));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp,
                         input string m);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        wt = 0;
        do begin
            @(posedge clk);
            wt++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "read data");
        check(er, 1'b0, "read error");
        check(wt, 1, "wait states");
    endtask

    task automatic frame(input ick_frame_t t, input logic [7:0] p,
                         input logic m, input logic [12:0] o,
                         input logic [3:0] h, input logic [5:0] d,
                         input logic g);
        parser_i.send(t, p, m, o, h, d, g);
        nfr++;
        #1;
        check(kv, 1'b1, "key valid");
    endtask

    task automatic v4(input logic [7:0] p, input logic m,
                      input logic [12:0] o, input logic [3:0] h,
                      input logic [2:0] fl, input logic [1:0] tu);
        frame(ICK_FT_IPV4, p, m, o, h, 6'h2a, 1'b1);
        check(k7[182:180], fl, "ipv4 flags");
        check(k7[188:183], 6'h2a, "dscp");
        check(k7[268:205], {32'h0, DST[31:0]}, "dst low");
        check(k7[348:285], {32'h0, SRC[31:0]}, "src low");
        check({k7[284:269], k7[204:189]}, 32'h0, "high");
        check(k7[350:349], tu, "l4 flags");
        check(k7[366:351], tu[0] ? L4[31:16] : 16'h0, "sport");
        @(posedge clk);
        #1;
        check(kv, 1'b0, "pulse");
    endtask

    // Tests run in order; each ends with a one-line report.
    initial begin
        ick_frame_t tl[5];
        logic [31:0] bv[5];
        tl = '{ICK_FT_LLC, ICK_FT_SNAP, ICK_FT_OAM, ICK_FT_ARP, ICK_FT_ETYPE};
        bv = '{32'h00c80064, 32'h00c80064, 32'h17700fa0, 32'h01230123,
               32'h000a000a};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        check(kv, 1'b0, "reset valid");
        apb(1'b1, 8'h25, 32'h00000fff);
        check(er, 1'b1, "unaligned");
        rdchk(8'h24, 32'h1);
        rdchk(8'h00, 32'hffff0000);
        apb(1'b0, 8'h2c, 32'h0);
        check(er, 1'b1, "unmapped");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h28, 32'hffffffff);
        rdchk(8'h28, 32'h0);
        $display("register test done");
        // Fragment and options frames are the ones entries must mask.
        v4(8'h06, 1'b1, 13'h0, 4'h6, 3'b101, 2'b11);
        v4(8'h11, 1'b0, 13'h5, 4'h5, 3'b011, 2'b01);
        v4(8'h01, 1'b0, 13'h0, 4'h5, 3'b000, 2'b00);
        $display("ipv4 test done");
        frame(ICK_FT_IPV6, 8'h06, 1'b1, 13'h3, 4'h6, 6'h15, 1'b1);
        check(k7[182:180], 3'b000, "v6 flags");
        check(k7[204:189], DST[127:112], "dst high");
        check(k7[268:205], DST[63:0], "dst low");
        check(k7[284:269], SRC[127:112], "src high");
        check(k7[348:285], SRC[63:0], "src low");
        check(k7[366:349], {L4[31:16], 2'b11}, "l4");
        check(k5[70:65], 6'h15, "dscp5");
        check(k5[198:71], DST, "dst5");
        check(k5[326:199], SRC, "src5");
        check(k5[336:327], {2'b11, 8'h06}, "proto5");
        check(k5[376:345], L4, "payload5");
        frame(ICK_FT_IPV6, 8'h11, 1'b0, 13'h0, 4'h5, 6'h15, 1'b1);
        check(k5[336:335], 2'b01, "udp5");
        frame(ICK_FT_IPV6, 8'h3a, 1'b0, 13'h0, 4'h5, 6'h15, 1'b1);
        check(k5[336:335], 2'b00, "other5");
        $display("ipv6 test done");
        for (int i = 0; i < 5; i++) begin
            frame(tl[i], 8'h06, 1'b1, 13'h1, 4'h6, 6'h3, 1'b0);
            ed = PAY[63:0];
            es = PAY[127:64];
            if (tl[i] == ICK_FT_LLC) begin
                ed = PAY[71:8];
                es = {8'h5a, PAY[127:72]};
            end else if (tl[i] == ICK_FT_SNAP) begin
                ed = PAY[87:24];
                es = {24'h0c0d0e, PAY[127:88]};
            end
            check(k7[268:205], ed, "ovl dst");
            check(k7[348:285], es, "ovl src");
            check({k7[350:349], k7[182:180]}, 5'h0, "ovl flags");
        end
        frame(ick_frame_t'(3'h7), 8'h06, 1'b0, 13'h0, 4'h5, 6'h3, 1'b0);
        check(k7[268:205], 64'h0, "unknown dst");
        check(k7[348:285], 64'h0, "unknown src");
        $display("overload test done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'(4 * i), bv[i]);
        end
        apb(1'b1, 8'h20, 32'h000358d1);
        rdchk(8'h20, 32'h000358d1);
        frame(ICK_FT_IPV6, 8'h06, 1'b0, 13'h0, 4'h5, 6'h0a, 1'b1);
        check(k7[374:367], 8'h1d, "mask7");
        check(k5[344:337], 8'h1d, "mask5");
        frame(ICK_FT_IPV4, 8'h11, 1'b0, 13'h0, 4'h5, 6'h09, 1'b0);
        check(k7[374:367], 8'h05, "untagged");
        frame(ICK_FT_IPV4, 8'h01, 1'b0, 13'h0, 4'h5, 6'h0a, 1'b1);
        check(k7[374:367], 8'h18, "no ports");
        rdchk(8'h28, {16'h0, 8'(nfr), 8'h18});
        apb(1'b1, 8'h24, 32'h123);
        frame(ICK_FT_IPV4, 8'h01, 1'b0, 13'h0, 4'h5, 6'h00, 1'b0);
        check(k7[374:367], 8'h08, "port vid");
        $display("range test done");
        finish_test();
    end

    // A hang costs a mismatch; the run is far shorter than this.
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule // ick_key_builder_tb
